// ---- src/bmpc_pkg.sv ----
// Purpose: constants for the burst mode and protection controller
// Assumes: 200 MHz clock, 32-bit AXI4-Lite register slave
// Notes:   times kept in their own unit, cycle counts derived
package bmpc_pkg;

    localparam int unsigned CLK_MHZ = 200;

    // timing
    localparam int unsigned BURST_FREQ_HZ   = 52000;
    localparam int unsigned BURST_PERIOD_CY = (CLK_MHZ * 1000000) / BURST_FREQ_HZ;
    localparam int unsigned BURST_HALF_CY   = BURST_PERIOD_CY / 2;
    localparam int unsigned BLANK_OL_MS     = 24;
    localparam int unsigned BLANK_OL_CY     = BLANK_OL_MS * 1000 * CLK_MHZ;
    localparam int unsigned MAX_ON_US       = 30;
    localparam int unsigned MAX_ON_CY       = MAX_ON_US * CLK_MHZ;
    localparam int unsigned ENTRY_BLANK_US  = 50;
    localparam int unsigned ENTRY_BLANK_CY  = ENTRY_BLANK_US * CLK_MHZ;
    localparam int unsigned OVP_BLANK_US    = 1;
    localparam int unsigned OVP_BLANK_CY    = OVP_BLANK_US * CLK_MHZ;
    localparam int unsigned SS_MS           = 12;
    localparam int unsigned SS_CY           = SS_MS * 1000 * CLK_MHZ;

    // valley counter
    localparam logic [2:0] VALLEY_MAX  = 3'h7;
    localparam logic [2:0] VALLEY_LOAD = 3'h1;

    // register byte addresses
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_MASK   = 8'h04;
    localparam logic [7:0] ADDR_STATE  = 8'h08;
    localparam logic [7:0] ADDR_CTRL   = 8'h0C;

    // status/mask bit positions
    localparam int unsigned EV_BURST_IN  = 0;
    localparam int unsigned EV_BURST_OUT = 1;
    localparam int unsigned EV_AUTORST   = 2;
    localparam int unsigned EV_LATCH     = 3;
    localparam int unsigned EV_MAXON     = 4;
    localparam int unsigned EV_WIDTH     = 5;

    localparam logic [31:0] MASK_RESET = 32'h0000_0000;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    typedef enum logic [2:0]
    {
        ST_OFF     = 3'b000,
        ST_SOFT    = 3'b001,
        ST_NORMAL  = 3'b010,
        ST_BURST   = 3'b011,
        ST_AUTORST = 3'b100,
        ST_LATCHED = 3'b101
    } bmpc_mode_e;

endpackage

// ---- src/bmpc_sync.sv ----
// Purpose: two-flop synchroniser for a bank of comparator flags
// Assumes: flags are asynchronous to clk
// Notes:   first stage is read only by the second stage
`timescale 1ns/100ps
module bmpc_sync
#(
    parameter int unsigned WIDTH = 12
)
(
    // clock and reset
    input  wire logic             clk,
    input  wire logic             nrst,
    // flags
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            meta_q   <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule

// ---- src/bmpc_top.sv ----
// Purpose: burst mode entry/exit, burst pulse generator and fault supervisor
// Assumes: comparator flags arrive asynchronously; AXI4-Lite master on clk
// Notes:   analog thresholds live outside; this block only sees flags
// Summary of operation
// - feedback below burst entry level is the first burst entry condition
// - valley counter at maximum seven is the second entry condition
// - both conditions must persist a full entry blanking period to enter burst
// - in paused burst, feedback above resume level restarts bias and pulses
// - burst turn-on comes from a fixed 52 kHz timer, not valley sensing
// - burst turn-off at reduced current limit or half timer period, first wins
// - feedback at pause level resets bias and stops pulses until resume level
// - feedback above exit level leaves burst and restores full current
// - on burst exit the valley counter is loaded with one
// - feedback held high for 24 ms blanking enters auto-restart
// - valley pin above output ovp level in off-time latches off after blanking
// - latched-off clears only when supply falls below latch release level
// - over-temperature enters auto-restart
// - current sense above short winding level during on-time latches off
// - latched-off cycles startup cell between supply off and on levels
// - gate forced low once high longer than maximum on-time
// - supply under or overvoltage resets control and holds switch off
// - auto-restart resumes with fresh soft-start once supply reaches on level
`timescale 1ns/100ps
module bmpc_top
    import bmpc_pkg::*;
#(
    parameter int unsigned OL_BLANK_CYCLES = BLANK_OL_CY,
    parameter int unsigned SS_CYCLES       = SS_CY,
    parameter int unsigned ENTRY_CYCLES    = ENTRY_BLANK_CY,
    parameter int unsigned MAXON_CYCLES    = MAX_ON_CY
)
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        nrst,
    // comparator flags, asynchronous
    input  wire logic        fb_below_entry,
    input  wire logic        fb_above_resume,
    input  wire logic        fb_at_pause,
    input  wire logic        fb_above_exit,
    input  wire logic        fb_overload,
    input  wire logic        cs_burst_limit,
    input  wire logic        cs_short_winding,
    input  wire logic        valley_ovp,
    input  wire logic        over_temp,
    input  wire logic        supply_fault,
    input  wire logic        supply_on,
    input  wire logic        supply_release,
    // normal-mode request and valley counter from the valley logic
    input  wire logic        normal_gate_req,
    input  wire logic [2:0]  valley_count,
    // outputs
    output logic             gate_q,
    output logic             bias_en_q,
    output logic             full_current_q,
    output logic             valley_load_q,
    output logic             startup_en_q,
    output logic             soft_start_q,
    output logic             irq_q,
    // AXI4-Lite slave
    input  wire logic [7:0]  s_awaddr,
    input  wire logic        s_awvalid,
    output logic             s_awready,
    input  wire logic [31:0] s_wdata,
    input  wire logic [3:0]  s_wstrb,
    input  wire logic        s_wvalid,
    output logic             s_wready,
    output logic [1:0]       s_bresp,
    output logic             s_bvalid,
    input  wire logic        s_bready,
    input  wire logic [7:0]  s_araddr,
    input  wire logic        s_arvalid,
    output logic             s_arready,
    output logic [31:0]      s_rdata,
    output logic [1:0]       s_rresp,
    output logic             s_rvalid,
    input  wire logic        s_rready
);

    logic [11:0] flags;
    bmpc_mode_e  mode_q;
    bmpc_mode_e  mode_d;
    logic [31:0] entry_cnt_q;
    logic [31:0] ol_cnt_q;
    logic [31:0] ovp_cnt_q;
    logic [31:0] on_cnt_q;
    logic [31:0] ss_cnt_q;
    logic [15:0] tmr_q;
    logic [EV_WIDTH-1:0] status_q;
    logic [EV_WIDTH-1:0] mask_q;
    logic        force_pause_q;
    logic        aw_hold_q;
    logic        w_hold_q;
    logic [7:0]  awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;

    bmpc_sync #(.WIDTH(12)) u_sync
    (
        .clk      (clk),
        .nrst     (nrst),
        .async_in ({supply_release, supply_on, supply_fault, over_temp,
                    valley_ovp, cs_short_winding, cs_burst_limit, fb_overload,
                    fb_above_exit, fb_at_pause, fb_above_resume, fb_below_entry}),
        .sync_out (flags)
    );

    wire fb_low      = flags[0];
    wire fb_resume   = flags[1];
    wire fb_pause    = flags[2];
    wire fb_exit     = flags[3];
    wire fb_ol       = flags[4];
    wire cs_bl       = flags[5];
    wire cs_sw       = flags[6];
    wire v_ovp       = flags[7];
    wire otp         = flags[8];
    wire sup_fault   = flags[9];
    wire sup_on      = flags[10];
    wire sup_release = flags[11];

    // entry, fault and burst pulse conditions
    wire entry_cond  = fb_low && (valley_count == VALLEY_MAX);
    wire entry_done  = entry_cond && (entry_cnt_q >= ENTRY_CYCLES - 1);
    wire running     = (mode_q == ST_SOFT) || (mode_q == ST_NORMAL) || (mode_q == ST_BURST);
    wire ol_done     = fb_ol && (ol_cnt_q >= OL_BLANK_CYCLES - 1);
    wire ovp_done    = v_ovp && !gate_q && (ovp_cnt_q >= OVP_BLANK_CY - 1);
    wire sw_fault    = cs_sw && gate_q;
    wire latch_ev    = running && (ovp_done || sw_fault);
    wire auto_ev     = running && (ol_done || otp || sup_fault);
    wire burst_exit  = (mode_q == ST_BURST) && fb_exit;
    wire maxon_hit   = gate_q && (on_cnt_q >= MAXON_CYCLES - 1);
    wire tmr_wrap    = (tmr_q == 16'(BURST_PERIOD_CY - 1));
    wire burst_on    = (mode_q == ST_BURST) && !force_pause_q && tmr_wrap;
    wire burst_off   = cs_bl || (tmr_q >= 16'(BURST_HALF_CY - 1));

    always_comb
    begin
        mode_d = mode_q;
        unique case (mode_q)
            ST_OFF:     if (sup_on) mode_d = ST_SOFT;
            ST_SOFT:    if (ss_cnt_q >= SS_CYCLES - 1) mode_d = ST_NORMAL;
            ST_NORMAL:  if (entry_done) mode_d = ST_BURST;
            ST_BURST:   if (burst_exit) mode_d = ST_NORMAL;
            ST_AUTORST: if (sup_on && !sup_fault) mode_d = ST_SOFT;
            ST_LATCHED: if (sup_release) mode_d = ST_OFF;
            default:    mode_d = ST_OFF;
        endcase
        if (latch_ev)
            mode_d = ST_LATCHED;
        else if (auto_ev)
            mode_d = ST_AUTORST;
    end

    // timers and mode
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            mode_q      <= ST_OFF;
            entry_cnt_q <= 32'h0;
            ol_cnt_q    <= 32'h0;
            ovp_cnt_q   <= 32'h0;
            ss_cnt_q    <= 32'h0;
            tmr_q       <= 16'h0;
        end
        else
        begin
            mode_q      <= mode_d;
            entry_cnt_q <= (entry_cond && mode_q == ST_NORMAL) ? entry_cnt_q + 32'h1 : 32'h0;
            ol_cnt_q    <= (fb_ol && running) ? ol_cnt_q + 32'h1 : 32'h0;
            ovp_cnt_q   <= (v_ovp && !gate_q && running) ? ovp_cnt_q + 32'h1 : 32'h0;
            ss_cnt_q    <= (mode_q == ST_SOFT) ? ss_cnt_q + 32'h1 : 32'h0;
            tmr_q       <= (mode_q != ST_BURST || tmr_wrap) ? 16'h0 : tmr_q + 16'h1;
        end
    end

    // gate, bias and supervisory outputs
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            gate_q         <= 1'b0;
            on_cnt_q       <= 32'h0;
            bias_en_q      <= 1'b0;
            full_current_q <= 1'b1;
            valley_load_q  <= 1'b0;
            startup_en_q   <= 1'b1;
            soft_start_q   <= 1'b0;
        end
        else
        begin
            on_cnt_q <= gate_q ? on_cnt_q + 32'h1 : 32'h0;
            if (mode_d == ST_LATCHED || mode_d == ST_AUTORST || mode_d == ST_OFF
                || maxon_hit)
                gate_q <= 1'b0;
            else if (mode_q == ST_BURST)
                gate_q <= burst_on ? 1'b1 : (gate_q && !burst_off);
            else
                gate_q <= normal_gate_req;
            if (mode_q == ST_BURST && fb_pause)
                bias_en_q <= 1'b0;
            else if (mode_q == ST_BURST && fb_resume)
                bias_en_q <= 1'b1;
            else if (mode_q != ST_BURST)
                bias_en_q <= running;
            full_current_q <= (mode_d != ST_BURST);
            valley_load_q  <= burst_exit;
            if (mode_q == ST_LATCHED || mode_q == ST_AUTORST || mode_q == ST_OFF)
                startup_en_q <= !sup_on;
            else
                startup_en_q <= 1'b0;
            soft_start_q <= (mode_d == ST_SOFT);
        end
    end

    // pulses held off from pause to resume
    always_ff @(posedge clk)
    begin
        if (!nrst)
            force_pause_q <= 1'b0;
        else if (mode_q != ST_BURST)
            force_pause_q <= 1'b1;
        else if (fb_resume)
            force_pause_q <= 1'b0;
        else if (fb_pause)
            force_pause_q <= 1'b1;
    end

    // register slave
    wire do_write = aw_hold_q && w_hold_q && !s_bvalid;
    wire [EV_WIDTH-1:0] events = {maxon_hit, latch_ev, auto_ev, burst_exit,
                                  (mode_q == ST_NORMAL) && entry_done};
    wire wr_status = do_write && (awaddr_q == ADDR_STATUS) && wstrb_q[0];
    wire wr_mask   = do_write && (awaddr_q == ADDR_MASK) && wstrb_q[0];
    wire wr_ctrl   = do_write && (awaddr_q == ADDR_CTRL);
    // the map fills 0x00-0x0F, so the upper nibble decides
    wire wr_ok     = (awaddr_q[7:4] == 4'h0);
    wire rd_ok     = (s_araddr[7:4] == 4'h0);
    wire [31:0] rd_mux =
        (s_araddr == ADDR_STATUS) ? {27'h0, status_q} :
        (s_araddr == ADDR_MASK)   ? {27'h0, mask_q} :
        (s_araddr == ADDR_STATE)  ? {24'h0, startup_en_q, bias_en_q, gate_q,
                                     force_pause_q, 1'b0, mode_q} : 32'h0;
    wire rd_take = s_arvalid && s_arready;

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            aw_hold_q <= 1'b0;
            w_hold_q  <= 1'b0;
            awaddr_q  <= 8'h0;
            wdata_q   <= 32'h0;
            wstrb_q   <= 4'h0;
            s_awready <= 1'b0;
            s_wready  <= 1'b0;
            s_bvalid  <= 1'b0;
            s_bresp   <= RESP_OKAY;
            s_arready <= 1'b0;
            s_rvalid  <= 1'b0;
            s_rdata   <= 32'h0;
            s_rresp   <= RESP_OKAY;
            status_q  <= '0;
            mask_q    <= MASK_RESET[EV_WIDTH-1:0];
            irq_q     <= 1'b0;
        end
        else
        begin
            s_awready <= !aw_hold_q && !s_awready && !s_bvalid;
            s_wready  <= !w_hold_q && !s_wready && !s_bvalid;
            if (s_awvalid && s_awready)
            begin
                aw_hold_q <= 1'b1;
                awaddr_q  <= {s_awaddr[7:2], 2'b00};
            end
            if (s_wvalid && s_wready)
            begin
                w_hold_q <= 1'b1;
                wdata_q  <= s_wdata;
                wstrb_q  <= s_wstrb;
            end
            if (do_write)
            begin
                aw_hold_q <= 1'b0;
                w_hold_q  <= 1'b0;
                s_bvalid  <= 1'b1;
                s_bresp   <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_bvalid && s_bready)
                s_bvalid <= 1'b0;
            s_arready <= !s_arready && !s_rvalid && s_arvalid;
            if (rd_take)
            begin
                s_rvalid <= 1'b1;
                s_rdata  <= rd_mux;
                s_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_rvalid && s_rready)
                s_rvalid <= 1'b0;
            // set wins over write-one-to-clear
            status_q <= (status_q & ~(wr_status ? wdata_q[EV_WIDTH-1:0] : '0)) | events;
            if (wr_mask)
                mask_q <= wdata_q[EV_WIDTH-1:0];
            irq_q <= |(status_q & mask_q);
        end
    end

    a_max_on_limit: assert property (@(posedge clk) disable iff (!nrst)
        gate_q [*8] |-> on_cnt_q < MAXON_CYCLES)
        else $error("max on-time passed");
    a_burst_half: assert property (@(posedge clk) disable iff (!nrst)
        (mode_q == ST_BURST && tmr_q > 16'(BURST_HALF_CY) && $past(mode_q) == ST_BURST)
        |-> !gate_q)
        else $error("burst duty over half");
    a_latch_gate: assert property (@(posedge clk) disable iff (!nrst)
        (latch_ev) |=> (mode_q == ST_LATCHED) && !gate_q)
        else $error("fault did not latch");
    a_latch_hold: assert property (@(posedge clk) disable iff (!nrst)
        (mode_q == ST_LATCHED && !sup_release) |=> mode_q == ST_LATCHED)
        else $error("latch left early");
    a_exit_load: assert property (@(posedge clk) disable iff (!nrst)
        burst_exit |=> valley_load_q && mode_q == ST_NORMAL)
        else $error("no valley load");
    a_entry_wait: assert property (@(posedge clk) disable iff (!nrst)
        ($past(mode_q) == ST_NORMAL && mode_q == ST_BURST) |-> $past(entry_cnt_q) >= ENTRY_CYCLES - 1)
        else $error("early burst entry");
    a_auto_fault: assert property (@(posedge clk) disable iff (!nrst)
        (running && sup_fault && !latch_ev) |=> mode_q == ST_AUTORST ##1 !gate_q)
        else $error("no auto-restart");
    a_burst_trig: assert property (@(posedge clk) disable iff (!nrst)
        ($rose(gate_q) && $past(mode_q) == ST_BURST) |-> $past(tmr_wrap))
        else $error("turn-on not timed");

endmodule

// ---- bench/bmpc_switch_model.sv ----
// Purpose: power switch, shunt and auxiliary winding at the gate output
// Assumes: gate high means the switch conducts
// Notes:   sense flags fall to zero while the switch is off
`timescale 1ns/100ps
module bmpc_switch_model
(
    // clock and gate
    input  wire logic        clk,
    input  wire logic        gate,
    // load behaviour set by the bench
    input  wire logic [11:0] limit_cy,
    input  wire logic        short_cmd,
    input  wire logic        ovp_cmd,
    // comparator flags
    output logic             cs_limit,
    output logic             cs_short,
    output logic             zc_ovp
);
    logic [11:0] on_cnt_q;
    always_ff @(posedge clk)
    begin
        on_cnt_q <= gate ? on_cnt_q + 12'h001 : 12'h000;
    end
    // zero: load too light for the limit
    assign cs_limit = gate && limit_cy != 12'h000 && on_cnt_q >= limit_cy;
    assign cs_short = gate && short_cmd;
    // ovp only shows in off-time
    assign zc_ovp   = !gate && ovp_cmd;
endmodule

// ---- bench/bmpc_top_tb_top.sv ----
// Purpose: self-checking bench for the burst and protection controller
// Assumes: shortened blanking, soft-start and max-on counts
// Notes:   register reads checked by a monitor
`timescale 1ns/100ps
module bmpc_top_tb_top
    import bmpc_pkg::*;
;
    localparam int unsigned OL_C = 100;
    localparam int unsigned SS_C = 50;
    localparam int unsigned EN_C = 20;
    localparam int unsigned MO_C = 2500;
    logic        clk = 1'b0, nrst = 1'b0, fb_below_entry = 1'b0, fb_above_resume = 1'b0;
    logic        fb_at_pause = 1'b0, fb_above_exit = 1'b0, fb_overload = 1'b0;
    logic        over_temp = 1'b0, supply_fault = 1'b0, supply_on = 1'b0;
    logic        supply_release = 1'b0, normal_gate_req = 1'b0, short_cmd = 1'b0;
    logic        ovp_cmd = 1'b0, s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0;
    logic        s_arvalid = 1'b0, s_rready = 1'b0;
    logic [2:0]  valley_count = 3'h0;
    logic [11:0] limit_cy = 12'h000;
    logic [7:0]  s_awaddr = 8'h00, s_araddr = 8'h00;
    logic [31:0] s_wdata = 32'h0, s_rdata;
    logic        cs_burst_limit, cs_short_winding, valley_ovp, gate_q, bias_en_q;
    logic        full_current_q, valley_load_q, startup_en_q, soft_start_q, irq_q;
    logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
    logic [1:0]  s_bresp, s_rresp, bq[$];
    logic [65:0] rq[$];
    int          bad_count = 0, checks_done = 0;

    always #2.5 clk = ~clk;

    bmpc_top
    #(
        .OL_BLANK_CYCLES(OL_C), .SS_CYCLES(SS_C), .ENTRY_CYCLES(EN_C), .MAXON_CYCLES(MO_C)
    )
    dut
    (
        .clk(clk), .nrst(nrst), .fb_below_entry(fb_below_entry),
        .fb_above_resume(fb_above_resume), .fb_at_pause(fb_at_pause),
        .fb_above_exit(fb_above_exit), .fb_overload(fb_overload),
        .cs_burst_limit(cs_burst_limit), .cs_short_winding(cs_short_winding),
        .valley_ovp(valley_ovp), .over_temp(over_temp), .supply_fault(supply_fault),
        .supply_on(supply_on), .supply_release(supply_release),
        .normal_gate_req(normal_gate_req), .valley_count(valley_count), .gate_q(gate_q),
        .bias_en_q(bias_en_q), .full_current_q(full_current_q),
        .valley_load_q(valley_load_q), .startup_en_q(startup_en_q),
        .soft_start_q(soft_start_q), .irq_q(irq_q), .s_awaddr(s_awaddr),
        .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(4'hF),
        .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
        .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
        .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp),
        .s_rvalid(s_rvalid), .s_rready(s_rready)
    );

    bmpc_switch_model partner
    (
        .clk(clk), .gate(gate_q), .limit_cy(limit_cy), .short_cmd(short_cmd),
        .ovp_cmd(ovp_cmd), .cs_limit(cs_burst_limit), .cs_short(cs_short_winding),
        .zc_ovp(valley_ovp)
    );

    task automatic summarize();
        if (bad_count == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic oops(input string m);
        $display("Error %0t: %s", $time, m);
        bad_count++;
    endtask

    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp,
                            input logic [31:0] msk, input string m);
        checks_done++;
        if ((got & msk) !== exp)
            oops(m);
    endtask

    task automatic cmp_bit(input logic got, input logic exp, input string m);
        checks_done++;
        if (got !== exp)
            oops(m);
    endtask

    task automatic cmp_span(input int got, input int lo, input int hi, input string m);
        checks_done++;
        if (got < lo || got > hi)
            oops(m);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        bq.push_back(er);
        @(posedge clk);
        s_awaddr <= a;
        s_wdata <= d;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        for (n = 0; n < 50 && (s_awvalid || s_wvalid || !s_bvalid); n++)
        begin
            @(posedge clk);
            if (s_awready)
                s_awvalid <= 1'b0;
            if (s_wready)
                s_wvalid <= 1'b0;
        end
        s_bready <= 1'b0;
        if (n == 50)
        begin
            oops("write stalled");
            summarize();
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
                      input logic [1:0] er);
        int n;
        rq.push_back({er, m, e});
        @(posedge clk);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        for (n = 0; n < 50 && (s_arvalid || !s_rvalid); n++)
        begin
            @(posedge clk);
            if (s_arready)
                s_arvalid <= 1'b0;
        end
        s_rready <= 1'b0;
        if (n == 50)
        begin
            oops("read stalled");
            summarize();
        end
    endtask

    task automatic mode_is(input bmpc_mode_e md);
        rd(ADDR_STATE, {29'h0, md}, 32'h0000_0007, RESP_OKAY);
    endtask

    task automatic wait_gate(input logic lvl, input int lim);
        int n;
        for (n = 0; n < lim && gate_q !== lvl; n++)
            @(posedge clk);
        if (n == lim)
        begin
            oops("gate timeout");
            summarize();
        end
    endtask

    task automatic go_normal();
        supply_on <= 1'b1;
        tick(12);
        mode_is(ST_SOFT);
        cmp_bit(soft_start_q, 1'b1, "soft start");
        tick(SS_C + 20);
        mode_is(ST_NORMAL);
        supply_on <= 1'b0;
    endtask

    // oldest note first
    always @(posedge clk)
    begin
        if (s_rvalid === 1'b1 && s_rready === 1'b1 && rq.size() > 0)
        begin
            cmp_word(s_rdata, rq[0][31:0], rq[0][63:32], "read data");
            cmp_word({30'h0, s_rresp}, {30'h0, rq[0][65:64]}, 32'h3, "read resp");
            void'(rq.pop_front());
        end
        if (s_bvalid === 1'b1 && s_bready === 1'b1 && bq.size() > 0)
            cmp_word({30'h0, s_bresp}, {30'h0, bq.pop_front()}, 32'h3, "write resp");
    end

    initial
    begin
        int  n;
        int  i;
        time t0;
        void'($urandom(30657));
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        rd(ADDR_STATE, 32'h0000_0080, 32'h0000_0087, RESP_OKAY);
        rd(ADDR_MASK, MASK_RESET, 32'hFFFF_FFFF, RESP_OKAY);
        wr(ADDR_CTRL, $urandom, RESP_OKAY);
        rd(ADDR_CTRL, CTRL_RESET, 32'hFFFF_FFFF, RESP_OKAY);
        wr(8'h14, 32'h0000_001F, RESP_SLVERR);
        rd(8'h10, 32'h0, 32'h0, RESP_SLVERR);
        go_normal();
        valley_count <= 3'($urandom_range(6, 0));
        fb_below_entry <= 1'b1;
        tick(EN_C + 20);
        mode_is(ST_NORMAL);
        valley_count <= VALLEY_MAX;
        fb_below_entry <= 1'b0;
        tick(4);
        fb_below_entry <= 1'b1;
        tick($urandom_range(EN_C - 6, 1));
        fb_below_entry <= 1'b0;
        tick(20);
        mode_is(ST_NORMAL);
        fb_below_entry <= 1'b1;
        tick(EN_C + 20);
        mode_is(ST_BURST);
        cmp_bit(full_current_q, 1'b0, "burst current");
        fb_below_entry <= 1'b0;
        normal_gate_req <= 1'b1;
        limit_cy <= 12'h01E;
        for (i = 0; i < 2; i++)
        begin
            fb_above_resume <= 1'b1;
            tick(8);
            fb_above_resume <= 1'b0;
            rd(ADDR_STATE, 32'h0000_0043, 32'h0000_0057, RESP_OKAY);
            if (i == 0)
            begin
                wait_gate(1'b1, 8000);
                t0 = $time;
                wait_gate(1'b0, 4000);
                cmp_span(int'(($time - t0) / 5), 30, 38, "limited on time");
                wait_gate(1'b1, 8000);
                cmp_span(int'(($time - t0) / 5), BURST_PERIOD_CY - 2,
                         BURST_PERIOD_CY + 2, "burst period");
                limit_cy <= 12'h000;
                t0 = $time;
                wait_gate(1'b0, 4000);
                cmp_span(int'(($time - t0) / 5), BURST_HALF_CY - 2,
                         BURST_HALF_CY + 2, "duty limit");
                fb_at_pause <= 1'b1;
                tick(8);
                fb_at_pause <= 1'b0;
                rd(ADDR_STATE, 32'h0000_0013, 32'h0000_0057, RESP_OKAY);
                n = 0;
                repeat (4000)
                begin
                    @(posedge clk);
                    n += (gate_q === 1'b1);
                end
                cmp_span(n, 0, 0, "paused pulses");
            end
        end
        normal_gate_req <= 1'b0;
        fb_above_exit <= 1'b1;
        n = 0;
        repeat (20)
        begin
            @(posedge clk);
            n += (valley_load_q === 1'b1);
        end
        fb_above_exit <= 1'b0;
        cmp_span(n, 1, 1, "valley load pulse");
        mode_is(ST_NORMAL);
        cmp_bit(full_current_q, 1'b1, "full current");
        rd(ADDR_STATUS, 32'h0000_0003, 32'h0000_0003, RESP_OKAY);
        wr(ADDR_STATUS, 32'h0000_0003, RESP_OKAY);
        rd(ADDR_STATUS, 32'h0, 32'h0000_001F, RESP_OKAY);
        wr(ADDR_MASK, 32'h0000_0010, RESP_OKAY);
        normal_gate_req <= 1'b1;
        wait_gate(1'b1, 50);
        t0 = $time;
        wait_gate(1'b0, MO_C + 50);
        cmp_span(int'(($time - t0) / 5), MO_C - 2, MO_C + 3, "max on time");
        normal_gate_req <= 1'b0;
        tick(5);
        cmp_bit(irq_q, 1'b1, "irq raised");
        rd(ADDR_MASK, 32'h0000_0010, 32'h0000_001F, RESP_OKAY);
        wr(ADDR_MASK, 32'h0, RESP_OKAY);
        tick(3);
        cmp_bit(irq_q, 1'b0, "irq masked");
        wr(ADDR_MASK, 32'h0000_0010, RESP_OKAY);
        wr(ADDR_STATUS, 32'h0000_0010, RESP_OKAY);
        tick(3);
        cmp_bit(irq_q, 1'b0, "irq cleared");
        // overload, over-temperature, supply fault in turn
        for (i = 0; i < 3; i++)
        begin
            fb_overload <= (i == 0);
            over_temp <= (i == 1);
            supply_fault <= (i == 2);
            tick(OL_C + 20);
            mode_is(ST_AUTORST);
            cmp_bit(gate_q, 1'b0, "gate in restart");
            fb_overload <= 1'b0;
            over_temp <= 1'b0;
            supply_fault <= 1'b0;
            go_normal();
        end
        rd(ADDR_STATUS, 32'h0000_0004, 32'h0000_0004, RESP_OKAY);
        ovp_cmd <= 1'b1;
        tick(OVP_BLANK_CY + 20);
        mode_is(ST_LATCHED);
        ovp_cmd <= 1'b0;
        cmp_bit(startup_en_q, 1'b1, "startup on");
        supply_on <= 1'b1;
        tick(8);
        cmp_bit(startup_en_q, 1'b0, "startup off");
        supply_on <= 1'b0;
        tick(8);
        cmp_bit(startup_en_q, 1'b1, "startup again");
        mode_is(ST_LATCHED);
        supply_release <= 1'b1;
        tick(8);
        mode_is(ST_OFF);
        supply_release <= 1'b0;
        go_normal();
        normal_gate_req <= 1'b1;
        short_cmd <= 1'b1;
        tick(30);
        mode_is(ST_LATCHED);
        cmp_bit(gate_q, 1'b0, "gate latched off");
        normal_gate_req <= 1'b0;
        short_cmd <= 1'b0;
        rd(ADDR_STATUS, 32'h0000_0008, 32'h0000_0008, RESP_OKAY);
        summarize();
    end
endmodule
